//--- include/drive_ctrl_pkg.sv
// Purpose: constants for the drive control word decoder
// Assumes: 20-bit serial words, most significant bit first
// Notes:   field positions and reset values of the decoded word
package drive_ctrl_pkg;
    localparam int WORD_WIDTH        = 20;
    localparam int ADDR_HI_POS       = 19;
    localparam int ADDR_LO_POS       = 18;
    localparam logic [1:0] ADDR_DRIVE_CONTROL = 2'h0;
    localparam int COIL_A_SIGN_POS   = 17;
    localparam int COIL_A_MAG_HI     = 16;
    localparam int COIL_A_MAG_LO     = 9;
    localparam int COIL_B_SIGN_POS   = 8;
    localparam int COIL_B_MAG_HI     = 7;
    localparam int COIL_B_MAG_LO     = 0;
    localparam int INTERP_POS        = 9;
    localparam int BOTH_EDGE_POS     = 8;
    localparam int MICROSTEP_RES_HI           = 3;
    localparam int MICROSTEP_RES_LO           = 0;
    localparam int INTERP_FACTOR     = 16;
    localparam logic [3:0] MICROSTEP_RES_MAX_CODE = 4'h8;
    localparam logic [8:0] RESET_MICROSTEPS = 9'h100;
    localparam logic [7:0] RESET_MAG = 8'h00;
    localparam logic [19:0] RESET_WORD = 20'h00000;
endpackage

//--- rtl/pin_sync.sv
// Purpose: two-flop synchroniser for a group of pins
// Assumes: inputs asynchronous to clock_i
// Notes:   first stage read only by the second stage
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    // pins
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1)
    begin : g_width_check
        $error("synchroniser needs at least one pin");
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            meta_reg <= '1;
            sync_o   <= '1;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule

//--- rtl/drive_control_word_decode.sv
// Purpose: shift in serial words, latch on chip select release, decode
// Assumes: serial clock idles low, data sampled on its rising edge
// Notes:   step_input_off comes from the driver configuration logic
//
// Overview of operation
// - mode bit high: word holds sign and magnitude for both coils
// - mode bit low: word configures interpolation, edges, microstep resolution
// - bit 17 gives coil A current direction
// - bits 16..9 give unsigned coil A magnitude, msb first
// - bit 8 gives coil B current direction
// - bits 7..0 give unsigned coil B magnitude, msb first
// - bit 9 enables sixteenfold step interpolation
// - bit 8 makes both step edges advance position
// - bits 19..18 equal to zero address the drive control word
// - last 20 bits before chip select rises are latched on its rise when their bits 19..18 are zero
`timescale 1ns/1ps
module drive_control_word_decode
    import drive_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // serial bus pins
    input  wire logic       serial_clk_i,
    input  wire logic       serial_data_i,
    input  wire logic       chip_select_n_i,
    // mode from driver configuration
    input  wire logic       step_input_off_i,
    // coil current commands
    output logic            coil_a_sign_o,
    output logic [7:0]      coil_a_magnitude_o,
    output logic            coil_b_sign_o,
    output logic [7:0]      coil_b_magnitude_o,
    // step input configuration
    output logic            step_interp_en_o,
    output logic            both_edge_step_o,
    output logic [3:0]      microstep_res_o,
    output logic [8:0]      microsteps_per_quarter_o,
    // word latch event
    output logic            word_latched_o
);
    // ************************************************
    // elaboration checks
    // ************************************************
    generate
        if (ADDR_HI_POS != WORD_WIDTH - 1)
        begin : g_addr_check
            $error("address field must end the word");
        end
        if (ADDR_LO_POS != ADDR_HI_POS - 1)
        begin : g_addr_pair_check
            $error("address field must be two bits");
        end
        if (COIL_A_MAG_HI - COIL_A_MAG_LO != 7)
        begin : g_mag_a_check
            $error("coil A magnitude must be eight bits");
        end
        if (COIL_B_MAG_HI - COIL_B_MAG_LO != 7)
        begin : g_mag_b_check
            $error("coil B magnitude must be eight bits");
        end
        if (COIL_A_SIGN_POS != COIL_A_MAG_HI + 1)
        begin : g_sign_a_check
            $error("coil A sign must sit above its magnitude");
        end
        if (COIL_B_SIGN_POS != COIL_B_MAG_HI + 1)
        begin : g_sign_b_check
            $error("coil B sign must sit above its magnitude");
        end
        if (MICROSTEP_RES_HI - MICROSTEP_RES_LO != 3)
        begin : g_microstep_res_check
            $error("resolution code must be four bits");
        end
    endgenerate

    // ************************************************
    // pin synchronisation and edge detection
    // ************************************************
    logic [2:0] pins_sync;
    logic       sclk_prev_reg;
    logic       csn_prev_reg;
    logic       sclk_rise;
    logic       csn_rise;

    pin_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .async_i ({serial_clk_i, serial_data_i, chip_select_n_i}),
        .sync_o  (pins_sync)
    );

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            sclk_prev_reg <= 1'b0;
            csn_prev_reg  <= 1'b1;
        end
        else
        begin
            sclk_prev_reg <= pins_sync[2];
            csn_prev_reg  <= pins_sync[0];
        end
    end

    assign sclk_rise = pins_sync[2] & ~sclk_prev_reg & ~pins_sync[0];
    assign csn_rise  = pins_sync[0] & ~csn_prev_reg;

    // ************************************************
    // shift register
    // ************************************************
    logic [WORD_WIDTH-1:0] shift_reg;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            shift_reg <= RESET_WORD;
        else if (sclk_rise)
            shift_reg <= {shift_reg[WORD_WIDTH-2:0], pins_sync[1]};
    end

    // ************************************************
    // word latch
    // ************************************************
    logic [WORD_WIDTH-1:0] ctrl_word_reg;
    logic                  addressed;

    assign addressed = ({shift_reg[ADDR_HI_POS], shift_reg[ADDR_LO_POS]}
                        == ADDR_DRIVE_CONTROL);

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            ctrl_word_reg <= RESET_WORD;
        else if (csn_rise && addressed)
            ctrl_word_reg <= shift_reg;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            word_latched_o <= 1'b0;
        else
            word_latched_o <= csn_rise & addressed;
    end

    // ************************************************
    // coil current layout
    // ************************************************
    // direct current mode
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            coil_a_sign_o      <= 1'b0;
            coil_a_magnitude_o <= RESET_MAG;
            coil_b_sign_o      <= 1'b0;
            coil_b_magnitude_o <= RESET_MAG;
        end
        else if (step_input_off_i)
        begin
            coil_a_sign_o      <= ctrl_word_reg[COIL_A_SIGN_POS];
            coil_a_magnitude_o <= ctrl_word_reg[COIL_A_MAG_HI:COIL_A_MAG_LO];
            coil_b_sign_o      <= ctrl_word_reg[COIL_B_SIGN_POS];
            coil_b_magnitude_o <= ctrl_word_reg[COIL_B_MAG_HI:COIL_B_MAG_LO];
        end
        else
        begin
            coil_a_sign_o      <= 1'b0;
            coil_a_magnitude_o <= RESET_MAG;
            coil_b_sign_o      <= 1'b0;
            coil_b_magnitude_o <= RESET_MAG;
        end
    end

    // ************************************************
    // step input layout
    // ************************************************
    logic [8:0] microsteps_next;

    always_comb
    begin
        if (ctrl_word_reg[MICROSTEP_RES_HI:MICROSTEP_RES_LO] > MICROSTEP_RES_MAX_CODE)
            microsteps_next = 9'h001;
        else
            microsteps_next = RESET_MICROSTEPS >> ctrl_word_reg[MICROSTEP_RES_HI:MICROSTEP_RES_LO];
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            step_interp_en_o         <= 1'b0;
            both_edge_step_o         <= 1'b0;
            microstep_res_o          <= 4'h0;
            microsteps_per_quarter_o <= RESET_MICROSTEPS;
        end
        else if (!step_input_off_i)
        begin
            step_interp_en_o         <= ctrl_word_reg[INTERP_POS];
            both_edge_step_o         <= ctrl_word_reg[BOTH_EDGE_POS];
            microstep_res_o          <= ctrl_word_reg[MICROSTEP_RES_HI:MICROSTEP_RES_LO];
            microsteps_per_quarter_o <= microsteps_next;
        end
        else
        begin
            step_interp_en_o         <= 1'b0;
            both_edge_step_o         <= 1'b0;
            microstep_res_o          <= 4'h0;
            microsteps_per_quarter_o <= RESET_MICROSTEPS;
        end
    end
endmodule

//--- testbench/drive_control_word_decode_monitor.sv
// Purpose: port checks of the word decoder
// Assumes: mode input in the clock domain
// Notes:   bound to the design top
`timescale 1ns/1ps
module drive_control_word_decode_monitor
    import drive_ctrl_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       reset_i,
    input wire logic       serial_clk_i,
    input wire logic       serial_data_i,
    input wire logic       chip_select_n_i,
    input wire logic       step_input_off_i,
    input wire logic       coil_a_sign_o,
    input wire logic [7:0] coil_a_magnitude_o,
    input wire logic       coil_b_sign_o,
    input wire logic [7:0] coil_b_magnitude_o,
    input wire logic       step_interp_en_o,
    input wire logic       both_edge_step_o,
    input wire logic [3:0] microstep_res_o,
    input wire logic [8:0] microsteps_per_quarter_o,
    input wire logic       word_latched_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    a_coil_mode_quiet: assert property (step_input_off_i [*2] |->
        !step_interp_en_o && !both_edge_step_o && microstep_res_o == 4'h0) else $error("step out");
    a_step_mode_quiet: assert property ((!step_input_off_i) [*2] |->
        {coil_a_sign_o, coil_a_magnitude_o, coil_b_sign_o, coil_b_magnitude_o} == 18'h0)
        else $error("coil out");
    a_res_decode: assert property (microsteps_per_quarter_o ==
        (microstep_res_o > MICROSTEP_RES_MAX_CODE ? 9'h001 : RESET_MICROSTEPS >> microstep_res_o))
        else $error("microsteps");
    a_latch_single: assert property (word_latched_o |=> !word_latched_o)
        else $error("long pulse");
    a_latch_after_cs: assert property (word_latched_o |-> $past(chip_select_n_i, 2))
        else $error("early latch");
    a_quiet_selected: assert property ((!chip_select_n_i) [*6] |-> !word_latched_o)
        else $error("latch while selected");
    a_update_cause: assert property ($changed({coil_a_sign_o, coil_a_magnitude_o,
        coil_b_sign_o, coil_b_magnitude_o, step_interp_en_o, both_edge_step_o,
        microstep_res_o}) |-> $past(word_latched_o) ||
        ($past(step_input_off_i) != $past(step_input_off_i, 2)))
        else $error("update without cause");
    a_reset_clear: assert property (disable iff (1'b0) reset_i |=>
        microsteps_per_quarter_o == 9'h100 && !word_latched_o) else $error("reset value");
    cover property (word_latched_o && step_input_off_i);
    cover property (word_latched_o && !step_input_off_i);
    cover property (microsteps_per_quarter_o == 9'h001);
endmodule
bind drive_control_word_decode drive_control_word_decode_monitor mon_u (
    .clock_i(clock_i), .reset_i(reset_i), .serial_clk_i(serial_clk_i),
    .serial_data_i(serial_data_i), .chip_select_n_i(chip_select_n_i),
    .step_input_off_i(step_input_off_i), .coil_a_sign_o(coil_a_sign_o),
    .coil_a_magnitude_o(coil_a_magnitude_o), .coil_b_sign_o(coil_b_sign_o),
    .coil_b_magnitude_o(coil_b_magnitude_o), .step_interp_en_o(step_interp_en_o),
    .both_edge_step_o(both_edge_step_o), .microstep_res_o(microstep_res_o),
    .microsteps_per_quarter_o(microsteps_per_quarter_o), .word_latched_o(word_latched_o));

//--- testbench/serial_host_model.sv
// Purpose: host side of the serial bus
// Assumes: 32 ns serial clock, idle low
// Notes:   data inverted once released
`timescale 1ns/1ps
module serial_host_model (
    // serial bus pins
    output logic serial_clk_o,
    output logic serial_data_o,
    output logic chip_select_n_o
);
    initial
    begin
        serial_clk_o    = 1'b0;
        serial_data_o   = 1'b0;
        chip_select_n_o = 1'b1;
    end
    task automatic send(input logic [31:0] w, input int n);
        chip_select_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data_o = w[i];
            #16 serial_clk_o = 1'b1;
            #16 serial_clk_o = 1'b0;
        end
        #16 chip_select_n_o = 1'b1;
        serial_data_o = ~serial_data_o;
    endtask
endmodule

//--- testbench/drive_control_word_decode_tb.sv
// Purpose: self-checking bench of the word decoder
// Assumes: host model drives the serial pins
// Notes:   mode input driven 1 ns after the edge
`timescale 1ns/1ps
module drive_control_word_decode_tb;
    import drive_ctrl_pkg::*;
    logic       clock_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       mode    = 1'b0;
    logic       sclk, sdata, chip_select_n, lat, a_s, b_s, ip, be;
    logic [7:0] a_m, b_m;
    logic [3:0] res;
    logic [8:0] mpq;
    int         fails   = 0;
    int         n_tests = 0;
    always #2 clock_i = ~clock_i;
    serial_host_model host_u (.serial_clk_o(sclk), .serial_data_o(sdata),
        .chip_select_n_o(chip_select_n));
    drive_control_word_decode dut_u (.clock_i(clock_i), .reset_i(reset_i),
        .serial_clk_i(sclk), .serial_data_i(sdata), .chip_select_n_i(chip_select_n),
        .step_input_off_i(mode), .coil_a_sign_o(a_s), .coil_a_magnitude_o(a_m),
        .coil_b_sign_o(b_s), .coil_b_magnitude_o(b_m), .step_interp_en_o(ip),
        .both_edge_step_o(be), .microstep_res_o(res), .microsteps_per_quarter_o(mpq),
        .word_latched_o(lat));
    task automatic cmp(input string nm, input logic [19:0] e, input logic [19:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic outs(input logic [17:0] ec, input logic [14:0] es);
        cmp("coil", 20'(ec), 20'({a_s, a_m, b_s, b_m}));
        cmp("step", 20'(es), 20'({ip, be, res, mpq}));
    endtask
    task automatic put(input logic [31:0] w, input int n, input logic [17:0] ec,
        input logic [14:0] es);
        host_u.send(w, n);
        for (int k = 0; k < 8 && lat !== 1'b1; k++)
        begin
            @(posedge clock_i) #1;
        end
        cmp("latch", 20'h1, 20'(lat));
        @(posedge clock_i) #1;
        outs(ec, es);
    endtask
    task automatic set_mode(input logic m);
        @(posedge clock_i) #1 mode = m;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task automatic t_coil();
        outs(18'h0, 15'h100);
        set_mode(1'b1);
        put(32'h3F05A, 20, 18'h3F05A, 15'h100);
        $display("coil word done");
    endtask
    task automatic t_long();
        put(32'hF0017F, 24, 18'h0017F, 15'h100);
        host_u.send(32'h8A5A5, 20);
        repeat (12) @(posedge clock_i);
        outs(18'h0017F, 15'h100);
        $display("long frame and address done");
    endtask
    task automatic t_step();
        logic [3:0] c;
        set_mode(1'b0);
        for (int i = 0; i < 16; i++)
        begin
            c = 4'(i);
            put(32'({c[0], c[1], 4'h0, c}), 20, 18'h0,
                {c[0], c[1], c, (c > 4'h8) ? 9'h001 : 9'h100 >> c});
        end
        set_mode(1'b1);
        outs(18'h30F, 15'h100);
        $display("step modes done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clock_i);
        #1 reset_i = 1'b0;
        repeat (4) @(posedge clock_i);
        #1;
        t_coil();
        t_long();
        t_step();
        tally_and_finish();
    end
    initial
    begin
        #40000;
        fails++;
        tally_and_finish();
    end
endmodule
